// File: logic/pbcd_pkg.sv
// pbcd_pkg: constants and carrier types for the port b/c/d override block.
// assumes one system clock; all consumers import the whole package.
package pbcd_pkg;

   // ---------------------------------------------------------------
   // widths and bit positions
   // ---------------------------------------------------------------
   localparam int PBCD_W   = 8;
   localparam int SYNC_W   = 2 * PBCD_W;

   localparam int PB_CMP7  = 7;
   localparam int PB_CMP6  = 6;
   localparam int PB_CMP5  = 5;
   localparam int PB_CMP4  = 4;
   localparam int PB_MISO  = 3;
   localparam int PB_MOSI  = 2;
   localparam int PB_SCK   = 1;
   localparam int PB_SEL   = 0;

   localparam int PD_T2CK  = 7;
   localparam int PD_T1CK  = 6;
   localparam int PD_U1CK  = 5;
   localparam int PD_CAPT  = 4;
   localparam int PD_IRQ3  = 3;
   localparam int PD_IRQ2  = 2;
   localparam int PD_IRQ1  = 1;
   localparam int PD_IRQ0  = 0;

   // offset of the portd half inside the synchroniser vector
   localparam int SYNC_PD  = PBCD_W;

   // ---------------------------------------------------------------
   // values
   // ---------------------------------------------------------------
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [7:0]  BYTE_ONES  = 8'hff;
   localparam logic [15:0] SYNC_RST   = 16'h0000;
   localparam logic [2:0]  MASK_ZERO  = 3'h0;

   // high-address mask limits, index = port c bit
   localparam logic [7:0][2:0] PC_MASK_LIMIT = {3'h1, 3'h2, 3'h3, 3'h4,
                                                 3'h5, 3'h6, 3'h7, 3'h7};

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] oe;    // pin driven when high
      logic [7:0] val;   // pin level while driven
      logic [7:0] pu;    // pull-up on
   } pbcd_drive_s;

   typedef struct packed {
      logic t2_wave;
      logic t2_en;
      logic t1c_wave;
      logic t1c_en;
      logic t1b_wave;
      logic t1b_en;
      logic t1a_wave;
      logic t1a_en;
      logic t0_wave;
      logic t0_en;
   } pbcd_cmp_s;

   typedef struct packed {
      logic slave_out;
      logic master_out;
      logic sck_out;
   } pbcd_spi_tx_s;

   typedef struct packed {
      logic master_in;
      logic slave_in;
      logic sck_in;
      logic select_n;
      logic slave_active;
   } pbcd_spi_rx_s;

   typedef struct packed {
      logic       timer2_clock;
      logic       timer1_clock;
      logic       usart1_clock;
      logic       capture;
      logic [3:0] irq;
      logic       usart1_rx;
      logic       twi_data;
      logic       twi_clock;
   } pbcd_portd_s;

endpackage

// File: logic/pbcd_pin_override.sv
// pbcd_pin_override: pin override logic for ports b, c and d.
// assumes the port registers, timers, spi unit and memory controller sit on
// clk_in; pin inputs arrive asynchronously from the package pads.
//
// Function
// [RL1] pb7 drives timer2 compare output when enabled; direction bit must be one.
// [RL2] pb7 may carry timer1 channel c; modulator combines it with timer2 output.
// [RL3] pb6 drives timer1 channel b output while enabled; direction bit decides.
// [RL4] pb5 drives timer1 channel a output while enabled; direction bit decides.
// [RL5] pb4 drives timer0 compare output while enabled; direction bit decides.
// [RL6] pwm waveforms use the same value override path on pb7..pb4.
// [RL7] pb7..pb4 never override pull-up, direction or input enable.
// [RL8] miso forced input as master; as slave direction bit rules, slave data drives.
// [RL9] mosi forced input as slave; as master direction bit rules, master data drives.
// [RL10] sck forced input as slave; as master direction bit rules, clock drives.
// [RL11] select forced input as slave; value never overridden; level always routed.
// [RL12] slave role is active only while the select pin is held low.
// [RL13] forced spi inputs keep pull-up from port output bit, gated by disable.
// [RL14] miso splits into slave out and master in; mosi into master out, slave in.
// [RL15] port c pins 7..0 carry external address bits 15..8.
// [RL16] pc7..pc4 override while enabled and mask below 1,2,3,4.
// [RL17] pc3..pc0 override while enabled and mask below 5,6,7,7.
// [RL18] legacy mode makes port c output only.
// [RL19] legacy mode reads the high-address mask as zero.
// [RL20] port d pins 7..0 map to timer, usart1, capture, interrupt, two-wire functions.
// [RL21] legacy mode removes usart1, two-wire and timer1 channel c functions.
// [RL22] global pull-up disable suppresses every pull-up.
// [RL23] spi direction and pull-up overrides only while spi needs a forced input.
`timescale 1ns/10ps

module pbcd_pin_override
   import pbcd_pkg::*;
(
   input  wire logic         clk_in,                   // system clock, 250 MHz
   input  wire logic         rstn_in,                  // sync reset, active low
   input  wire logic [7:0]   portb_dir_in,             // port b direction register
   input  wire logic [7:0]   portb_out_in,             // port b output register
   input  wire logic [7:0]   portc_dir_in,             // port c direction register
   input  wire logic [7:0]   portc_out_in,             // port c output register
   input  wire logic         global_pullup_disable_in, // kills every pull-up
   input  wire logic         serial_periph_enable_in,  // spi enabled
   input  wire logic         serial_master_select_in,  // spi master role
   input  wire logic         ext_mem_enable_in,        // external memory on
   input  wire logic [2:0]   high_addr_mask_in,        // high-address mask field
   input  wire logic         legacy_mode_in,           // legacy compatibility mode
   input  wire pbcd_cmp_s    compare_in,               // timer waveforms and enables
   input  wire pbcd_spi_tx_s spi_tx_in,                // spi outgoing levels
   input  wire logic [7:0]   ext_addr_hi_in,           // external address 15..8
   input  wire logic [7:0]   portb_pin_in,             // port b pad levels, async
   input  wire logic [7:0]   portd_pin_in,             // port d pad levels, async
   output pbcd_drive_s       portb_drive_out,          // port b pad control
   output pbcd_drive_s       portc_drive_out,          // port c pad control
   output pbcd_spi_rx_s      spi_rx_out,               // spi incoming levels
   output pbcd_portd_s       portd_func_out,           // port d function inputs
   output logic              ext_func_avail_out        // usart1/two-wire/ch c usable
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // three stages; a level is accepted only once stages two and three agree
   logic [SYNC_W-1:0] sync1_q, sync1_d;
   logic [SYNC_W-1:0] sync2_q, sync2_d;
   logic [SYNC_W-1:0] sync3_q, sync3_d;
   logic [SYNC_W-1:0] filt_q, filt_d;
   logic [SYNC_W-1:0] agree;

   always_comb begin
      sync1_d = {portd_pin_in, portb_pin_in};
      sync2_d = sync1_q;
      sync3_d = sync2_q;
      agree   = ~(sync2_q ^ sync3_q);
      filt_d  = (sync2_q & agree) | (filt_q & ~agree);
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         sync3_q <= SYNC_RST;
         filt_q  <= SYNC_RST;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
         filt_q  <= filt_d;
      end
   end

   logic [7:0] pb_in;
   logic [7:0] pd_in;
   assign pb_in = filt_q[PBCD_W-1:0];
   assign pd_in = filt_q[SYNC_PD +: PBCD_W];

   // ---------------------------------------------------------------
   // common terms
   // ---------------------------------------------------------------
   logic       spi_master;
   logic       spi_slave;
   logic       t1c_en;
   logic       cmp7_en;
   logic       cmp7_wave;
   logic [2:0] mask_eff;

   always_comb begin
      spi_master = serial_periph_enable_in & serial_master_select_in;
      spi_slave  = serial_periph_enable_in & ~serial_master_select_in;
      t1c_en     = compare_in.t1c_en & ~legacy_mode_in;                    // RL21
      cmp7_en    = compare_in.t2_en | t1c_en;                              // RL1
      // both channels on: port bit 7 picks or/and of the two waveforms
      if (compare_in.t2_en && t1c_en) begin
         cmp7_wave = portb_out_in[PB_CMP7]
                   ? (compare_in.t2_wave | compare_in.t1c_wave)
                   : (compare_in.t2_wave & compare_in.t1c_wave);           // RL2
      end else if (t1c_en) begin
         cmp7_wave = compare_in.t1c_wave;                                  // RL2
      end else begin
         cmp7_wave = compare_in.t2_wave;                                   // RL1
      end
      mask_eff = legacy_mode_in ? MASK_ZERO : high_addr_mask_in;           // RL19
   end

   // ---------------------------------------------------------------
   // port b override terms
   // ---------------------------------------------------------------
   logic [7:0] pb_dir_override_en, pb_dir_override_val, pb_value_override_en, pb_value_override_val, pb_pullup_override_en, pb_pullup_override_val;

   always_comb begin
      // timer pins touch only value and its enable; pwm uses the same path
      pb_dir_override_en = BYTE_ZERO;                                                 // RL7
      pb_dir_override_val = BYTE_ZERO;
      pb_pullup_override_en = BYTE_ZERO;
      pb_pullup_override_val = BYTE_ZERO;
      pb_value_override_en = BYTE_ZERO;
      pb_value_override_val = BYTE_ZERO;
      pb_value_override_en[PB_CMP7] = cmp7_en;                                          // RL6
      pb_value_override_val[PB_CMP7] = cmp7_wave;
      pb_value_override_en[PB_CMP6] = compare_in.t1b_en;                                // RL3
      pb_value_override_val[PB_CMP6] = compare_in.t1b_wave;
      pb_value_override_en[PB_CMP5] = compare_in.t1a_en;                                // RL4
      pb_value_override_val[PB_CMP5] = compare_in.t1a_wave;
      pb_value_override_en[PB_CMP4] = compare_in.t0_en;                                 // RL5
      pb_value_override_val[PB_CMP4] = compare_in.t0_wave;
      // forced inputs: direction low, pull-up from the port bit
      pb_dir_override_en[PB_MISO] = spi_master;                                       // RL8
      pb_dir_override_en[PB_MOSI] = spi_slave;                                        // RL9
      pb_dir_override_en[PB_SCK]  = spi_slave;                                        // RL10
      pb_dir_override_en[PB_SEL]  = spi_slave;                                        // RL11
      pb_pullup_override_en[PB_MISO:PB_SEL] = pb_dir_override_en[PB_MISO:PB_SEL];                  // RL23
      pb_pullup_override_val[PB_MISO:PB_SEL] = portb_out_in[PB_MISO:PB_SEL]
                              & {(PB_MISO - PB_SEL + 1){~global_pullup_disable_in}}; // RL13
      pb_value_override_en[PB_MISO] = spi_slave;                                        // RL14
      pb_value_override_val[PB_MISO] = spi_tx_in.slave_out;
      pb_value_override_en[PB_MOSI] = spi_master;                                       // RL14
      pb_value_override_val[PB_MOSI] = spi_tx_in.master_out;
      pb_value_override_en[PB_SCK]  = spi_master;                                       // RL10
      pb_value_override_val[PB_SCK]  = spi_tx_in.sck_out;
   end

   // ---------------------------------------------------------------
   // port c override terms
   // ---------------------------------------------------------------
   logic [7:0] pc_ovr;
   logic [7:0] pc_dir_override_en, pc_value_override_en, pc_pullup_override_en;

   // ---------------------------------------------------------------
   // per-pin merge of override terms with port registers
   // ---------------------------------------------------------------
   pbcd_drive_s pb_drive_d, pb_drive_q;
   pbcd_drive_s pc_drive_d, pc_drive_q;

   for (genvar i = 0; i < PBCD_W; i++) begin : g_pin
      logic pb_dir, pc_dir;

      // mask compare per pin, always zero mask in legacy mode
      assign pc_ovr[i]  = ext_mem_enable_in & (mask_eff < PC_MASK_LIMIT[i]); // RL16 RL17
      assign pc_dir_override_en[i] = pc_ovr[i] | legacy_mode_in;                       // RL18
      assign pc_value_override_en[i] = pc_ovr[i];                                        // RL15
      assign pc_pullup_override_en[i] = pc_ovr[i];

      assign pb_dir = pb_dir_override_en[i] ? pb_dir_override_val[i] : portb_dir_in[i];
      // port c override always drives the pin out
      assign pc_dir = pc_dir_override_en[i] ? 1'b1 : portc_dir_in[i];

      // per-bit assigns, not a process per pin: each carrier bit keeps one driver
      assign pb_drive_d.oe[i]  = pb_dir;
      assign pb_drive_d.val[i] = pb_value_override_en[i] ? pb_value_override_val[i] : portb_out_in[i];
      assign pb_drive_d.pu[i]  = pb_pullup_override_en[i] ? pb_pullup_override_val[i]
                           : (~pb_dir & portb_out_in[i] & ~global_pullup_disable_in); // RL22
      assign pc_drive_d.oe[i]  = pc_dir;
      assign pc_drive_d.val[i] = pc_value_override_en[i] ? ext_addr_hi_in[i] : portc_out_in[i]; // RL15
      assign pc_drive_d.pu[i]  = pc_pullup_override_en[i] ? 1'b0
                           : (~pc_dir & portc_out_in[i] & ~global_pullup_disable_in); // RL22
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         pb_drive_q <= '0;
         pc_drive_q <= '0;
      end else begin
         pb_drive_q <= pb_drive_d;
         pc_drive_q <= pc_drive_d;
      end
   end

   assign portb_drive_out = pb_drive_q;
   assign portc_drive_out = pc_drive_q;

   // ---------------------------------------------------------------
   // incoming functions: spi and port d
   // ---------------------------------------------------------------
   pbcd_spi_rx_s spi_rx_d, spi_rx_q;
   pbcd_portd_s  pd_func_d, pd_func_q;
   logic         avail_d, avail_q;

   always_comb begin
      spi_rx_d.master_in    = pb_in[PB_MISO];                              // RL14
      spi_rx_d.slave_in     = pb_in[PB_MOSI];                              // RL14
      spi_rx_d.sck_in       = pb_in[PB_SCK];
      spi_rx_d.select_n     = pb_in[PB_SEL];                               // RL11
      spi_rx_d.slave_active = spi_slave & ~pb_in[PB_SEL];                  // RL12
      avail_d                = ~legacy_mode_in;                            // RL21
      pd_func_d.timer2_clock = pd_in[PD_T2CK];                             // RL20
      pd_func_d.timer1_clock = pd_in[PD_T1CK];
      pd_func_d.usart1_clock = pd_in[PD_U1CK] & avail_d;                   // RL21
      pd_func_d.capture      = pd_in[PD_CAPT];
      pd_func_d.irq          = pd_in[PD_IRQ3:PD_IRQ0];                     // RL20
      pd_func_d.usart1_rx    = pd_in[PD_IRQ2] & avail_d;                   // RL21
      pd_func_d.twi_data     = pd_in[PD_IRQ1] & avail_d;
      pd_func_d.twi_clock    = pd_in[PD_IRQ0] & avail_d;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         spi_rx_q  <= '0;
         pd_func_q <= '0;
         avail_q   <= 1'b0;
      end else begin
         spi_rx_q  <= spi_rx_d;
         pd_func_q <= pd_func_d;
         avail_q   <= avail_d;
      end
   end

   assign spi_rx_out         = spi_rx_q;
   assign portd_func_out     = pd_func_q;
   assign ext_func_avail_out = avail_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_pb6_timer;
      compare_in.t1b_en |=> portb_drive_out.val[PB_CMP6] == $past(compare_in.t1b_wave);
   endproperty
   a_pb6_timer: assert property (p_pb6_timer) else $error("pb6 timer value wrong"); // RL3

   property p_pb_dir_kept;
      1'b1 |=> portb_drive_out.oe[PB_CMP7:PB_CMP4] == $past(portb_dir_in[PB_CMP7:PB_CMP4]);
   endproperty
   a_pb_dir_kept: assert property (p_pb_dir_kept) else $error("pb7..4 direction overridden"); // RL7

   property p_pb7_legacy;
      (legacy_mode_in && !compare_in.t2_en) |=> portb_drive_out.val[PB_CMP7]
                                               == $past(portb_out_in[PB_CMP7]);
   endproperty
   a_pb7_legacy: assert property (p_pb7_legacy) else $error("channel c seen in legacy"); // RL21

   property p_miso_master;
      spi_master |=> !portb_drive_out.oe[PB_MISO];
   endproperty
   a_miso_master: assert property (p_miso_master) else $error("miso not input as master"); // RL8

   property p_mosi_slave;
      spi_slave |=> !portb_drive_out.oe[PB_MOSI] && !portb_drive_out.oe[PB_SCK]
                    && !portb_drive_out.oe[PB_SEL];
   endproperty
   a_mosi_slave: assert property (p_mosi_slave) else $error("slave inputs driven"); // RL9

   property p_sck_master;
      (spi_master && portb_dir_in[PB_SCK]) |=> portb_drive_out.oe[PB_SCK]
                 && portb_drive_out.val[PB_SCK] == $past(spi_tx_in.sck_out);
   endproperty
   a_sck_master: assert property (p_sck_master) else $error("sck not driven as master"); // RL10

   property p_sel_value;
      1'b1 |=> portb_drive_out.val[PB_SEL] == $past(portb_out_in[PB_SEL]);
   endproperty
   a_sel_value: assert property (p_sel_value) else $error("select value overridden"); // RL11

   property p_pud;
      global_pullup_disable_in |=> portb_drive_out.pu == BYTE_ZERO
                                   && portc_drive_out.pu == BYTE_ZERO;
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up on while disabled"); // RL22

   property p_pc_addr;
      (ext_mem_enable_in && mask_eff == MASK_ZERO) |=> portc_drive_out.oe == BYTE_ONES
                 && portc_drive_out.val == $past(ext_addr_hi_in);
   endproperty
   a_pc_addr: assert property (p_pc_addr) else $error("port c address missing"); // RL15

   property p_pc_legacy;
      legacy_mode_in |=> portc_drive_out.oe == BYTE_ONES;
   endproperty
   a_pc_legacy: assert property (p_pc_legacy) else $error("port c not output in legacy"); // RL18

   property p_slave_active;
      spi_rx_out.slave_active |-> !spi_rx_out.select_n;
   endproperty
   a_slave_active: assert property (p_slave_active) else $error("slave active, select high"); // RL12

   property p_pd_sync;
      ($stable(portd_pin_in[PD_T2CK]))[*5] |=> portd_func_out.timer2_clock
                                              == $past(portd_pin_in[PD_T2CK], 2);
   endproperty
   a_pd_sync: assert property (p_pd_sync) else $error("port d level not routed"); // RL20

   property p_miso_slave;
      spi_slave |=> portb_drive_out.val[PB_MISO] == $past(spi_tx_in.slave_out);
   endproperty
   a_miso_slave: assert property (p_miso_slave) else $error("miso not slave data"); // RL14

   property p_forced_pu;
      (spi_master && !global_pullup_disable_in) |=> portb_drive_out.pu[PB_MISO]
                                                    == $past(portb_out_in[PB_MISO]);
   endproperty
   a_forced_pu: assert property (p_forced_pu) else $error("forced input pull-up wrong"); // RL13

   property p_spi_off;
      !serial_periph_enable_in |=> portb_drive_out.oe[PB_MISO:PB_SEL]
                                   == $past(portb_dir_in[PB_MISO:PB_SEL]);
   endproperty
   a_spi_off: assert property (p_spi_off) else $error("spi pins overridden while off"); // RL23

   // pc7 is the first pin handed back to the port as the mask grows
   property p_pc7_release;
      (ext_mem_enable_in && mask_eff >= PC_MASK_LIMIT[PBCD_W-1]) |=>
         portc_drive_out.oe[PBCD_W-1] == $past(portc_dir_in[PBCD_W-1]);
   endproperty
   a_pc7_release: assert property (p_pc7_release) else $error("pc7 kept by mask"); // RL16

   c_master:  cover property (spi_master ##1 portb_drive_out.oe[PB_MOSI]);
   c_slave:   cover property (spi_rx_out.slave_active);
   c_extmem:  cover property (ext_mem_enable_in && high_addr_mask_in != MASK_ZERO);
   c_both7:   cover property (compare_in.t2_en && t1c_en);

endmodule

// File: test/pbcd_pad_model.sv
// pbcd_pad_model: port b pads with the external circuitry behind them.
// assumes drive_in is the block's registered pad control for port b.
`timescale 1ns/10ps

module pbcd_pad_model
   import pbcd_pkg::*;
(
   input  wire logic        clk_in,     // system clock
   input  wire pbcd_drive_s drive_in,   // device pad control
   input  wire logic [7:0]  ext_oe_in,  // external drive enables
   input  wire logic [7:0]  ext_val_in, // external drive levels
   output logic [7:0]       pin_out     // resolved pad levels
);
   logic [7:0] flip_q = 8'h00;

   // an undriven, unpulled pad must not keep its last level
   // a released, unpulled pad settles at the inverse of its last held level
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < 8; i++) begin
         if (drive_in.oe[i] || ext_oe_in[i] || drive_in.pu[i]) begin
            flip_q[i] <= ~pin_out[i];
         end
      end
   end

   // outside world backs off while the device drives, avoiding contention
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (drive_in.oe[i]) begin
            pin_out[i] = drive_in.val[i];
         end else if (ext_oe_in[i]) begin
            pin_out[i] = ext_val_in[i];
         end else begin
            pin_out[i] = drive_in.pu[i] | flip_q[i];
         end
      end
   end
endmodule

// File: test/pbcd_pin_override_test.sv
// pbcd_pin_override_test: random self-checking bench for the pin override block.
// assumes the pad model on port b; port d pads are driven straight from here.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s expected %h seen %h", n, e, g); end end

module pbcd_pin_override_test
   import pbcd_pkg::*;
;
   typedef struct packed {logic [7:0] b; logic [7:0] d; logic lg; logic sp; logic ms;} pbcd_snap_s;

   logic         clk_in, rstn_in, global_pullup_disable, serial_periph_enable, serial_master_select, xmem, legacy, avail, ea;
   logic [7:0]   pb_dir, pb_out, pc_dir, pc_out, addr, pd_pin, ext_oe, ext_val;
   logic [7:0]   pb_pin;
   logic [2:0]   mask;
   pbcd_cmp_s    cmp;
   pbcd_spi_tx_s stx;
   pbcd_drive_s  b_drv, c_drv, eb, ec;
   pbcd_spi_rx_s rx, er;
   pbcd_portd_s  pd_f, ed;
   pbcd_snap_s   hist[$];
   pbcd_snap_s   s;
   int           error_cnt = 0, compares = 0, seed = 77, rst_cnt = 0;
   logic         stable;

   pbcd_pin_override u_pbcd_pin_override (.clk_in(clk_in), .rstn_in(rstn_in),
      .portb_dir_in(pb_dir), .portb_out_in(pb_out), .portc_dir_in(pc_dir),
      .portc_out_in(pc_out), .global_pullup_disable_in(global_pullup_disable), .serial_periph_enable_in(serial_periph_enable),
      .serial_master_select_in(serial_master_select), .ext_mem_enable_in(xmem), .high_addr_mask_in(mask),
      .legacy_mode_in(legacy), .compare_in(cmp), .spi_tx_in(stx), .ext_addr_hi_in(addr),
      .portb_pin_in(pb_pin), .portd_pin_in(pd_pin), .portb_drive_out(b_drv),
      .portc_drive_out(c_drv), .spi_rx_out(rx), .portd_func_out(pd_f),
      .ext_func_avail_out(avail));

   pbcd_pad_model u_pbcd_pad_model (.clk_in(clk_in), .drive_in(b_drv), .ext_oe_in(ext_oe),
      .ext_val_in(ext_val), .pin_out(pb_pin));

   // ---------------------------------------------------------------
   // reference model
   // ---------------------------------------------------------------
   function automatic pbcd_drive_s exp_b();
      pbcd_drive_s r;
      logic        c_en;
      r.oe = pb_dir;
      r.pu = ~pb_dir & pb_out & {8{~global_pullup_disable}};
      r.val = pb_out;
      r.val[4] = cmp.t0_en ? cmp.t0_wave : pb_out[4];
      r.val[5] = cmp.t1a_en ? cmp.t1a_wave : pb_out[5];
      r.val[6] = cmp.t1b_en ? cmp.t1b_wave : pb_out[6];
      c_en = cmp.t1c_en & ~legacy;
      if (cmp.t2_en && c_en) begin
         r.val[7] = pb_out[7] ? (cmp.t2_wave | cmp.t1c_wave) : (cmp.t2_wave & cmp.t1c_wave);
      end else if (cmp.t2_en) begin
         r.val[7] = cmp.t2_wave;
      end else if (c_en) begin
         r.val[7] = cmp.t1c_wave;
      end
      if (serial_periph_enable && serial_master_select) begin
         r.oe[3] = 1'b0;
         r.pu[3] = pb_out[3] & ~global_pullup_disable;
         r.val[2] = stx.master_out;
         r.val[1] = stx.sck_out;
      end
      if (serial_periph_enable && !serial_master_select) begin
         r.oe[2:0] = 3'h0;
         r.pu[2:0] = pb_out[2:0] & {3{~global_pullup_disable}};
         r.val[3] = stx.slave_out;
      end
      return r;
   endfunction

   function automatic pbcd_drive_s exp_c();
      pbcd_drive_s r;
      logic [2:0]  m;
      m = legacy ? 3'h0 : mask;
      r.oe = pc_dir | {8{legacy}};
      r.val = pc_out;
      r.pu = ~r.oe & pc_out & {8{~global_pullup_disable}};
      for (int i = 0; i < 8; i++) begin
         if (xmem && int'(m) < ((i == 0) ? 7 : 8 - i)) begin
            r.oe[i] = 1'b1;
            r.val[i] = addr[i];
            r.pu[i] = 1'b0;
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // monitor: expectations at the edge, comparison at the falling edge
   // ---------------------------------------------------------------
   always @(posedge clk_in) begin
      rst_cnt = rstn_in ? rst_cnt + 1 : 0;
      eb = exp_b();
      ec = exp_c();
      ea = ~legacy;
      s = '{b: pb_pin, d: pd_pin, lg: legacy, sp: serial_periph_enable, ms: serial_master_select};
      hist.push_front(s);
      if (hist.size() > 8) begin
         void'(hist.pop_back());
      end
      // pads pass a 4-stage filter, so only settled windows are judged
      stable = (hist.size() == 8);
      for (int i = 1; i < 7 && stable; i++) begin
         stable = (hist[i] == hist[0]);
      end
      s = hist[hist.size() > 4 ? 4 : 0];
      ed = '{timer2_clock: s.d[7], timer1_clock: s.d[6], usart1_clock: s.d[5] & ~s.lg,
             capture: s.d[4], irq: s.d[3:0], usart1_rx: s.d[2] & ~s.lg,
             twi_data: s.d[1] & ~s.lg, twi_clock: s.d[0] & ~s.lg};
      er = '{master_in: s.b[3], slave_in: s.b[2], sck_in: s.b[1], select_n: s.b[0],
             slave_active: s.sp & ~s.ms & ~s.b[0]};
   end

   always @(negedge clk_in) begin
      if (rst_cnt >= 2) begin
         `CHK("portb_oe", eb.oe, b_drv.oe)
         `CHK("portb_val", eb.val & eb.oe, b_drv.val & b_drv.oe)
         `CHK("portb_pu", eb.pu, b_drv.pu)
         `CHK("portc_oe", ec.oe, c_drv.oe)
         `CHK("portc_val", ec.val & ec.oe, c_drv.val & ec.oe)
         `CHK("portc_pu", ec.pu, c_drv.pu)
         `CHK("ext_avail", ea, avail)
      end
      if (rst_cnt >= 8 && stable) begin
         `CHK("portd_func", ed, pd_f)
         `CHK("spi_rx", er, rx)
      end
   end

   // ---------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // inputs held 8 cycles so the pad filter settles before judging
   task automatic run(input string name, input int n, input logic lg_force);
      int e0;
      e0 = error_cnt;
      repeat (n) begin
         @(posedge clk_in);
         #1;
         pb_dir = 8'($random(seed));
         pb_out = 8'($random(seed));
         pc_dir = 8'($random(seed));
         pc_out = 8'($random(seed));
         addr = 8'($random(seed));
         pd_pin = 8'($random(seed));
         ext_val = 8'($random(seed));
         ext_oe = (($random(seed) & 3) != 0) ? 8'hff : 8'($random(seed));
         {global_pullup_disable, serial_periph_enable, serial_master_select, xmem} = 4'($random(seed));
         mask = 3'($random(seed));
         legacy = lg_force | (($random(seed) & 7) == 0);
         cmp = 10'($random(seed));
         stx = 3'($random(seed));
         repeat (7) @(posedge clk_in);
      end
      $display("test %s ends, mismatches %0d", name, error_cnt - e0);
   endtask

   initial begin
      rstn_in = 1'b0;
      {pb_dir, pb_out, pc_dir, pc_out, addr, pd_pin, ext_val} = '0;
      ext_oe = 8'hff;
      {global_pullup_disable, serial_periph_enable, serial_master_select, xmem, legacy, mask, cmp, stx} = '0;
      repeat (16) @(posedge clk_in);
      #1;
      rstn_in = 1'b1;
      run("random mix", 400, 1'b0);
      run("legacy mode", 100, 1'b1);
      test_done();
   end

   initial begin
      #80000;
      error_cnt++;
      $display("unexpected run_length expected finish seen timeout");
      test_done();
   end
endmodule
